// ===== rtl/swsr_top.sv
// Supervisor core: sequence recorder, windowed watchdog, reset control
//
// Overview of operation
// - Recorder tick 25 us to 3200 us; timestamps are 8-bit tick counts
// - Primary edges start recording when idle, secondary optional; up/down kept
// - Latch tick per enabled rail: up above UV, down below off level
// - Valid record kept until cleared; new same-type start sets missed flag
// - Recorder runs full sequence even when valid flag already set
// - Sequence ends at tick maximum or when all enabled rails done
// - Running and start-source indications; optional reset on completion
// - Watchdog tick 200 us to 12.8 ms
// - On reset release watchdog opens extended first window, no closed phase
// - Challenge key answered with 8-bit LFSR step x^8+x^6+x^5+x^4+1
// - Simple mode: any key value is a valid refresh in the open window
// - Lock blocks watchdog register writes except key and lock
// - Early, wrong-key, missing flags clear on read; live open flag
// - Reset on every violation or only after two consecutive
// - Watchdog inactive while reset line is low
// - Closed window 8 x closed field ticks, then open 8 x open field
// - Refresh in closed window is a fault; restart after reset release
// - Valid refresh starts new closed window at once
// - First window is (open + closed) x (1 + 2 x first-update field)
// - Open-drain reset asserts on mapped faults, holds 6us/8ms/16ms/32ms
// - OV/UV comparators powered per enable, powerdown mode, off, status
// - Off comparator powered per enable, powerdown mode, primary, status
// - Reload defaults after primary power-down, optionally on watchdog reset
module swsr_top
	import swsr_pkg::*;
#(
	parameter int NCH            = 7,
	parameter int AW             = 8,
	parameter int P_REC_BASE_CYC = REC_TICK_CYC,
	parameter int P_WD_BASE_CYC  = WD_TICK_CYC,
	parameter int P_HOLD_CYC     = HOLD_BASE_CYC
)(
	input  wire logic           i_mclk,                   // 200 MHz clock
	input  wire logic           i_rst_b,                  // Sync reset
	input  wire logic           i_ce,                     // Clock enable
	input  wire logic           i_psel,                   // APB select
	input  wire logic           i_penable,                // APB enable
	input  wire logic           i_pwrite,                 // APB write
	input  wire logic [AW-1:0]  i_paddr,                  // APB address
	input  wire logic [31:0]    i_pwdata,                 // APB write data
	output logic      [31:0]    o_prdata,                 // APB read data
	output logic                o_pready,                 // APB ready
	output logic                o_pslverr,                // APB error
	input  wire logic           i_primary_enable_input,   // Enable pin 0
	input  wire logic           i_secondary_enable_input, // Enable pin 1
	input  wire logic [NCH-1:0] i_rail_uv_ok,             // Rail above UV
	input  wire logic [NCH-1:0] i_rail_off,               // Rail below off
	input  wire logic [NCH-1:0] i_mon_fault,              // OV/UV faults
	input  wire logic           i_reset_pin_in,           // Reset pin level
	output logic                o_reset_pin_out,          // Reset pin data
	output logic                o_reset_pin_oe_b,         // Low: drive pin
	output logic      [NCH-1:0] o_ovuv_power,             // OV/UV comp on
	output logic      [NCH-1:0] o_off_power,              // Off comp on
	output logic                o_reload_defaults         // Reload pulse
);

	localparam int SW = 3 + 3 * NCH;

	// Pin synchronisers: change accepted once stages two and three agree
	logic [SW-1:0] pin_raw;
	logic [SW-1:0] s1_reg;
	logic [SW-1:0] s2_reg;
	logic [SW-1:0] s3_reg;
	logic [SW-1:0] filt_reg;

	assign pin_raw = {i_reset_pin_in, i_mon_fault, i_rail_off,
		i_rail_uv_ok, i_secondary_enable_input, i_primary_enable_input};

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			filt_reg <= '0;
		end
		else if (i_ce)
		begin
			s1_reg   <= pin_raw;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
		end
	end

	logic           prim;
	logic           sec;
	logic [NCH-1:0] uv_ok;
	logic [NCH-1:0] off_st;
	logic [NCH-1:0] mfault;
	logic           rpin;

	assign prim   = filt_reg[0];
	assign sec    = filt_reg[1];
	assign uv_ok  = filt_reg[2 +: NCH];
	assign off_st = filt_reg[2+NCH +: NCH];
	assign mfault = filt_reg[2+2*NCH +: NCH];
	assign rpin   = filt_reg[SW-1];

	// APB slave, one wait state on every access
	logic        ack_reg;
	logic [31:0] prdata_reg;
	logic        err_reg;
	logic [31:0] rdata;
	logic        mapped;
	logic        xfer;
	logic        wr;
	logic        rd;
	logic [7:0]  ts_q;

	function automatic logic reg_hit(input logic [AW-1:0] a,
		input logic [7:0] off);
		return a == AW'(off);
	endfunction

	function automatic logic ts_hit(input logic [AW-1:0] a);
		return (a[AW-1:6] == (AW-6)'(TS_REGION)) && (a[4:2] != 3'h7)
			&& (a[1:0] == 2'h0);
	endfunction

	assign xfer      = i_psel & i_penable & ack_reg;
	assign wr        = xfer & i_pwrite;
	assign rd        = xfer & ~i_pwrite;
	assign o_pready  = ack_reg;
	assign o_pslverr = ack_reg & err_reg;
	assign o_prdata  = prdata_reg;

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			ack_reg    <= 1'b0;
			prdata_reg <= '0;
			err_reg    <= 1'b0;
		end
		else if (i_ce)
		begin
			ack_reg <= i_psel & i_penable & ~ack_reg;
			if (i_psel & i_penable & ~ack_reg)
			begin
				prdata_reg <= i_pwrite ? '0 : rdata;
				err_reg    <= ~mapped;
			end
		end
	end

	// Configuration and recorder state
	logic [5:0]      rec_cfg_reg;
	logic [7:0]      mon_cfg_reg;
	logic [6:0]      wd_div_reg;
	logic [7:0]      wd_win_reg;
	logic [4:0]      wd_ctl_reg;
	logic            lock_reg;
	logic [9:0]      rst_ctl_reg;
	logic [7:0]      key_reg;
	swsr_rec_state_t rec_state_reg;
	logic            dir_up_reg;
	logic            src_sec_reg;
	logic            store_en_reg;
	logic [NCH-1:0]  done_reg;
	logic [7:0]      tick_reg;
	logic            up_valid_reg;
	logic            dn_valid_reg;
	logic            up_miss_reg;
	logic            dn_miss_reg;
	logic            wd_miss_reg;
	logic            wd_key_reg;
	logic            wd_early_reg;
	swsr_wd_state_t  wd_state_reg;
	logic            wd_open;

	assign wd_open = (wd_state_reg == WD_FIRST) || (wd_state_reg == WD_OPEN);

	always_comb
	begin
		rdata  = '0;
		mapped = 1'b1;
		case (i_paddr)
			ADDR_REC_CFG:  rdata[5:0] = rec_cfg_reg;
			ADDR_REC_STAT: rdata[5:0] = {src_sec_reg,
				rec_state_reg == REC_RUN, dn_miss_reg, up_miss_reg,
				dn_valid_reg, up_valid_reg};
			ADDR_MON_CFG:  rdata[7:0] = mon_cfg_reg;
			ADDR_WD_DIV:   rdata[6:0] = wd_div_reg;
			ADDR_WD_WIN:   rdata[7:0] = wd_win_reg;
			ADDR_WD_CTL:   rdata[4:0] = wd_ctl_reg;
			ADDR_WD_KEY:   rdata[7:0] = key_reg;
			ADDR_WD_LOCK:  rdata[0]   = lock_reg;
			ADDR_WD_STAT:  rdata[3:0] = {wd_open, wd_early_reg,
				wd_key_reg, wd_miss_reg};
			ADDR_RST_CTL:  rdata[9:0] = rst_ctl_reg;
			default:
			begin
				if (ts_hit(i_paddr))
					rdata[7:0] = ts_q;
				else
					mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			rec_cfg_reg <= REC_CFG_RST;
			mon_cfg_reg <= MON_CFG_RST;
			wd_div_reg  <= WD_DIV_RST;
			wd_win_reg  <= WD_WIN_RST;
			wd_ctl_reg  <= WD_CTL_RST;
			lock_reg    <= 1'b0;
			rst_ctl_reg <= RST_CTL_RST;
		end
		else if (i_ce && wr)
		begin
			if (reg_hit(i_paddr, ADDR_REC_CFG))
				rec_cfg_reg <= i_pwdata[5:0];
			if (reg_hit(i_paddr, ADDR_MON_CFG))
				mon_cfg_reg <= i_pwdata[7:0];
			if (reg_hit(i_paddr, ADDR_WD_DIV) && !lock_reg)
				wd_div_reg <= i_pwdata[6:0];
			if (reg_hit(i_paddr, ADDR_WD_WIN) && !lock_reg)
				wd_win_reg <= i_pwdata[7:0];
			if (reg_hit(i_paddr, ADDR_WD_CTL) && !lock_reg)
				wd_ctl_reg <= i_pwdata[4:0];
			if (reg_hit(i_paddr, ADDR_WD_LOCK))
				lock_reg <= i_pwdata[0];
			if (reg_hit(i_paddr, ADDR_RST_CTL))
				rst_ctl_reg <= i_pwdata[9:0];
		end
	end

	// Sequence recorder
	logic           prim_d_reg;
	logic           sec_d_reg;
	logic           prim_edge;
	logic           sec_edge;
	logic           start;
	logic           start_up;
	logic [NCH-1:0] en;
	logic [NCH-1:0] hit;
	logic           fin;
	logic [23:0]    rec_base_reg;
	logic [7:0]     rec_sub_reg;
	logic [7:0]     sub_lim;
	logic [15:0]    ts_we;
	logic           stat_w1c;

	assign en        = mon_cfg_reg[NCH-1:0];
	assign prim_edge = prim ^ prim_d_reg;
	assign sec_edge  = (sec ^ sec_d_reg) & rec_cfg_reg[B_REC_SEC];
	assign start     = (rec_state_reg == REC_IDLE) & (prim_edge | sec_edge);
	assign start_up  = prim_edge ? prim : sec;
	assign hit       = {NCH{rec_state_reg == REC_RUN}} & en & ~done_reg
		& (dir_up_reg ? uv_ok : off_st);
	assign fin       = (rec_state_reg == REC_RUN) && ((tick_reg == 8'hff)
		|| (&(done_reg | hit | ~en)));
	assign sub_lim   = 8'((9'h001 << rec_cfg_reg[2:0]) - 9'h001);
	assign ts_we     = store_en_reg ? (dir_up_reg
		? 16'({hit}) : (16'({hit}) << 8)) : 16'h0000;
	assign stat_w1c  = wr & reg_hit(i_paddr, ADDR_REC_STAT);

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			prim_d_reg    <= 1'b0;
			sec_d_reg     <= 1'b0;
			rec_state_reg <= REC_IDLE;
			dir_up_reg    <= 1'b0;
			src_sec_reg   <= 1'b0;
			store_en_reg  <= 1'b0;
			done_reg      <= '0;
		end
		else if (i_ce)
		begin
			prim_d_reg <= prim;
			sec_d_reg  <= sec;
			case (rec_state_reg)
				REC_IDLE:
				begin
					if (start)
					begin
						rec_state_reg <= REC_RUN;
						dir_up_reg    <= start_up;
						src_sec_reg   <= ~prim_edge;
						store_en_reg  <= start_up ? ~up_valid_reg
							: ~dn_valid_reg;
						done_reg      <= '0;
					end
				end
				REC_RUN:
				begin
					done_reg <= done_reg | hit;
					if (fin)
						rec_state_reg <= REC_IDLE;
				end
				default: rec_state_reg <= REC_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			rec_base_reg <= '0;
			rec_sub_reg  <= '0;
			tick_reg     <= '0;
		end
		else if (i_ce)
		begin
			if (rec_state_reg != REC_RUN)
			begin
				rec_base_reg <= '0;
				rec_sub_reg  <= '0;
				tick_reg     <= '0;
			end
			else if (rec_base_reg != 24'(P_REC_BASE_CYC - 1))
				rec_base_reg <= rec_base_reg + 24'h000001;
			else
			begin
				rec_base_reg <= '0;
				if (rec_sub_reg != sub_lim)
					rec_sub_reg <= rec_sub_reg + 8'h01;
				else
				begin
					rec_sub_reg <= '0;
					if (tick_reg != 8'hff)
						tick_reg <= tick_reg + 8'h01;
				end
			end
		end
	end

	// Record flags; a set in the same cycle as a clear wins
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			up_valid_reg <= 1'b0;
			dn_valid_reg <= 1'b0;
			up_miss_reg  <= 1'b0;
			dn_miss_reg  <= 1'b0;
		end
		else if (i_ce)
		begin
			up_valid_reg <= (fin & store_en_reg & dir_up_reg)
				| (up_valid_reg & ~(stat_w1c & i_pwdata[B_RS_UVALID]));
			dn_valid_reg <= (fin & store_en_reg & ~dir_up_reg)
				| (dn_valid_reg & ~(stat_w1c & i_pwdata[B_RS_DVALID]));
			up_miss_reg  <= (start & start_up & up_valid_reg)
				| (up_miss_reg & ~(stat_w1c & i_pwdata[B_RS_UMISS]));
			dn_miss_reg  <= (start & ~start_up & dn_valid_reg)
				| (dn_miss_reg & ~(stat_w1c & i_pwdata[B_RS_DMISS]));
		end
	end

	swsr_ts_mem #(
		.DW    (8),
		.DEPTH (16),
		.AW    (4)
	) u_ts_mem (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_ce    (i_ce),
		.i_we    (ts_we),
		.i_wdata (tick_reg),
		.i_raddr (i_paddr[5:2]),
		.o_rdata (ts_q)
	);

	// Watchdog
	logic        rst_line_reg;
	logic        wd_active;
	logic [23:0] wd_base_reg;
	logic [5:0]  wd_sub_reg;
	logic        wd_tick;
	logic [11:0] wd_cnt_reg;
	logic [11:0] clo_len;
	logic [11:0] opn_len;
	logic [11:0] first_len;
	logic [11:0] len_cur;
	logic        phase_end;
	logic        kick;
	logic        key_ok;
	logic        good;
	logic        early_ev;
	logic        bad_ev;
	logic        miss_ev;
	logic        viol;
	logic        wd_fault;
	logic        pend_reg;
	logic        stat_rd;

	assign wd_active = wd_ctl_reg[B_WD_EN] & ~rst_line_reg & rpin;
	assign wd_tick   = (wd_base_reg == 24'(P_WD_BASE_CYC - 1))
		&& (wd_sub_reg == wd_div_reg[5:0]);
	assign clo_len   = {5'h00, wd_win_reg[7:4], 3'h0};
	assign opn_len   = {5'h00, wd_win_reg[3:0], 3'h0};
	assign first_len = 12'((clo_len + opn_len)
		* (12'h001 + {8'h00, wd_ctl_reg[2:0], 1'b0}));
	assign phase_end = wd_cnt_reg >= len_cur;
	assign kick      = wr & reg_hit(i_paddr, ADDR_WD_KEY);
	assign key_ok    = wd_div_reg[B_WD_SIMPLE]
		| (i_pwdata[7:0] == lfsr_next(key_reg));
	assign good      = kick & wd_open & key_ok;
	assign bad_ev    = kick & wd_open & ~key_ok;
	assign early_ev  = kick & (wd_state_reg == WD_CLOSED);
	assign miss_ev   = wd_open & phase_end & ~kick;
	assign viol      = early_ev | bad_ev | miss_ev;
	assign wd_fault  = viol & (~wd_ctl_reg[B_WD_TWO] | pend_reg);
	assign stat_rd   = rd & reg_hit(i_paddr, ADDR_WD_STAT);

	always_comb
	begin
		case (wd_state_reg)
			WD_FIRST:  len_cur = first_len;
			WD_CLOSED: len_cur = clo_len;
			WD_OPEN:   len_cur = opn_len;
			default:   len_cur = 12'h000;
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			wd_base_reg <= '0;
			wd_sub_reg  <= '0;
		end
		else if (i_ce)
		begin
			if (wd_state_reg == WD_OFF)
			begin
				wd_base_reg <= '0;
				wd_sub_reg  <= '0;
			end
			else if (wd_base_reg != 24'(P_WD_BASE_CYC - 1))
				wd_base_reg <= wd_base_reg + 24'h000001;
			else
			begin
				wd_base_reg <= '0;
				wd_sub_reg  <= wd_tick ? 6'h00 : wd_sub_reg + 6'h01;
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			wd_state_reg <= WD_OFF;
			wd_cnt_reg   <= '0;
		end
		else if (i_ce)
		begin
			if (!wd_active)
			begin
				wd_state_reg <= WD_OFF;
				wd_cnt_reg   <= '0;
			end
			else
			begin
				case (wd_state_reg)
					WD_OFF:
					begin
						wd_state_reg <= WD_FIRST;
						wd_cnt_reg   <= '0;
					end
					WD_FIRST, WD_OPEN:
					begin
						if (good | viol)
						begin
							wd_state_reg <= WD_CLOSED;
							wd_cnt_reg   <= '0;
						end
						else if (wd_tick)
							wd_cnt_reg <= wd_cnt_reg + 12'h001;
					end
					WD_CLOSED:
					begin
						if (early_ev)
							wd_cnt_reg <= '0;
						else if (phase_end)
						begin
							wd_state_reg <= WD_OPEN;
							wd_cnt_reg   <= '0;
						end
						else if (wd_tick)
							wd_cnt_reg <= wd_cnt_reg + 12'h001;
					end
					default: wd_state_reg <= WD_OFF;
				endcase
			end
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			pend_reg <= 1'b0;
			key_reg  <= KEY_RST;
		end
		else if (i_ce)
		begin
			if (!wd_active || good)
				pend_reg <= 1'b0;
			else if (viol)
				pend_reg <= wd_ctl_reg[B_WD_TWO] & ~pend_reg;
			if (good && !wd_div_reg[B_WD_SIMPLE])
				key_reg <= lfsr_next(key_reg);
		end
	end

	// Flags clear on read; an event in the read cycle survives
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			wd_miss_reg  <= 1'b0;
			wd_key_reg   <= 1'b0;
			wd_early_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			wd_miss_reg  <= miss_ev | (wd_miss_reg & ~stat_rd);
			wd_key_reg   <= bad_ev | (wd_key_reg & ~stat_rd);
			wd_early_reg <= early_ev | (wd_early_reg & ~stat_rd);
		end
	end

	// Reset output, reload and comparator power
	logic        fault_now;
	logic [23:0] hold_len;
	logic [23:0] hold_cnt_reg;

	assign fault_now = (|(mfault & rst_ctl_reg[NCH-1:0]))
		| (wd_fault & rst_ctl_reg[B_RST_WD])
		| (fin & rec_cfg_reg[B_REC_RST]);
	assign o_reset_pin_out  = 1'b0;
	assign o_reset_pin_oe_b = ~rst_line_reg;

	always_comb
	begin
		case (rst_ctl_reg[9:8])
			2'h0:    hold_len = 24'(HOLD_SHORT_CYC);
			2'h1:    hold_len = 24'(P_HOLD_CYC);
			2'h2:    hold_len = 24'(2 * P_HOLD_CYC);
			default: hold_len = 24'(4 * P_HOLD_CYC);
		endcase
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			rst_line_reg <= 1'b1;
			hold_cnt_reg <= 24'(HOLD_SHORT_CYC);
		end
		else if (i_ce)
		begin
			if (fault_now)
			begin
				rst_line_reg <= 1'b1;
				hold_cnt_reg <= hold_len;
			end
			else if (hold_cnt_reg != 24'h000000)
				hold_cnt_reg <= hold_cnt_reg - 24'h000001;
			else
				rst_line_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			o_reload_defaults <= 1'b0;
			o_ovuv_power      <= '0;
			o_off_power       <= '0;
		end
		else if (i_ce)
		begin
			o_reload_defaults <= (fin & ~dir_up_reg & ~src_sec_reg)
				| (wd_fault & rec_cfg_reg[B_REC_RLD]);
			o_ovuv_power <= en & ((~{NCH{mon_cfg_reg[B_MON_PD]}}
				& ~off_st) | {NCH{mon_cfg_reg[B_MON_PD] & ~prim
				& (rec_state_reg == REC_RUN)}});
			o_off_power  <= en & {NCH{~mon_cfg_reg[B_MON_PD] | prim
				| (rec_state_reg == REC_RUN)}};
		end
	end

endmodule

// ===== shared/swsr_pkg.sv
// Constants, register map and types for the supervisor watchdog core
package swsr_pkg;

	// Timing
	localparam int CLK_PERIOD_NS  = 5;
	localparam int REC_TICK_NS    = 25000;
	localparam int REC_TICK_CYC   = REC_TICK_NS / CLK_PERIOD_NS;
	localparam int WD_TICK_NS     = 200000;
	localparam int WD_TICK_CYC    = WD_TICK_NS / CLK_PERIOD_NS;
	localparam int HOLD_SHORT_NS  = 6000;
	localparam int HOLD_SHORT_CYC = (HOLD_SHORT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int HOLD_BASE_NS   = 8000000;
	localparam int HOLD_BASE_CYC  = (HOLD_BASE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;

	// Register byte addresses
	localparam logic [7:0] ADDR_REC_CFG  = 8'h00;
	localparam logic [7:0] ADDR_REC_STAT = 8'h04;
	localparam logic [7:0] ADDR_MON_CFG  = 8'h08;
	localparam logic [7:0] ADDR_WD_DIV   = 8'h0c;
	localparam logic [7:0] ADDR_WD_WIN   = 8'h10;
	localparam logic [7:0] ADDR_WD_CTL   = 8'h14;
	localparam logic [7:0] ADDR_WD_KEY   = 8'h18;
	localparam logic [7:0] ADDR_WD_LOCK  = 8'h1c;
	localparam logic [7:0] ADDR_WD_STAT  = 8'h20;
	localparam logic [7:0] ADDR_RST_CTL  = 8'h24;
	localparam int         TS_REGION     = 1;

	// Field positions
	localparam int B_REC_SEC   = 3;
	localparam int B_REC_RST   = 4;
	localparam int B_REC_RLD   = 5;
	localparam int B_RS_UVALID = 0;
	localparam int B_RS_DVALID = 1;
	localparam int B_RS_UMISS  = 2;
	localparam int B_RS_DMISS  = 3;
	localparam int B_MON_PD    = 7;
	localparam int B_WD_SIMPLE = 6;
	localparam int B_WD_EN     = 3;
	localparam int B_WD_TWO    = 4;
	localparam int B_RST_WD    = 7;

	// Reset values
	localparam logic [5:0] REC_CFG_RST = 6'h00;
	localparam logic [7:0] MON_CFG_RST = 8'h00;
	localparam logic [6:0] WD_DIV_RST  = 7'h00;
	localparam logic [7:0] WD_WIN_RST  = 8'h11;
	localparam logic [4:0] WD_CTL_RST  = 5'h00;
	localparam logic [9:0] RST_CTL_RST = 10'h080;
	localparam logic [7:0] KEY_RST     = 8'h5a;

	typedef enum logic [0:0] {
		REC_IDLE = 1'b0,
		REC_RUN  = 1'b1
	} swsr_rec_state_t;

	typedef enum logic [1:0] {
		WD_OFF    = 2'b00,
		WD_FIRST  = 2'b01,
		WD_CLOSED = 2'b10,
		WD_OPEN   = 2'b11
	} swsr_wd_state_t;

	function automatic logic [7:0] lfsr_next(input logic [7:0] k);
		return {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]};
	endfunction

endpackage

// ===== rtl/swsr_ts_mem.sv
// Timestamp store with per-word write enables and registered read
module swsr_ts_mem #(
	parameter int DW    = 8,
	parameter int DEPTH = 16,
	parameter int AW    = 4
)(
	input  wire logic             i_mclk,  // Clock
	input  wire logic             i_rst_b, // Sync reset, active low
	input  wire logic             i_ce,    // Clock enable
	input  wire logic [DEPTH-1:0] i_we,    // Word write enables
	input  wire logic [DW-1:0]    i_wdata, // Shared write data
	input  wire logic [AW-1:0]    i_raddr, // Read address
	output logic      [DW-1:0]    o_rdata  // Registered read data
);

	logic [DW-1:0] mem_reg [DEPTH];

	// All enabled words take the same value, so rails that rise together
	// get the same timestamp
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem_reg[i] <= '0;
		end
		else if (i_ce)
		begin
			for (int i = 0; i < DEPTH; i++)
				if (i_we[i])
					mem_reg[i] <= i_wdata;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b)
			o_rdata <= '0;
		else if (i_ce)
			o_rdata <= mem_reg[i_raddr];
	end

endmodule

// ===== test/swsr_checker.sv
// Port-level assertions for the supervisor core
module swsr_checker #(
	parameter int P_HOLD_CYC = 20
)(
	input wire logic       i_mclk,            // Clock
	input wire logic       i_rst_b,           // Reset, active low
	input wire logic       i_psel,            // APB select
	input wire logic       i_penable,         // APB enable
	input wire logic       o_pready,          // APB ready
	input wire logic       o_pslverr,         // APB error
	input wire logic       o_reset_pin_out,   // Reset pin data
	input wire logic       o_reset_pin_oe_b,  // Reset pin drive
	input wire logic [6:0] o_ovuv_power,      // OV/UV power
	input wire logic [6:0] o_off_power,       // Off power
	input wire logic       o_reload_defaults  // Reload pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	// Shortest hold is the smaller of 6 us and the scaled base
	localparam int HMIN = P_HOLD_CYC < 1200 ? P_HOLD_CYC : 1200;
	logic [11:0] low_cnt;
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_b || o_reset_pin_oe_b)
			low_cnt <= 12'h000;
		else if (low_cnt != 12'hfff)
			low_cnt <= low_cnt + 12'h001;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	property p_rdy; i_psel && !i_penable |=> !o_pready ##1 o_pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready not on 2nd access");
	property p_one; o_pready |=> !o_pready; endproperty
	a_one: assert property (p_one) else $error("pready too long");
	property p_err; o_pslverr |-> o_pready; endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	property p_pin; o_reset_pin_out == 1'b0; endproperty
	a_pin: assert property (p_pin) else $error("reset data high");
	property p_rst; disable iff (1'b0) !i_rst_b |=> !o_reset_pin_oe_b; endproperty
	a_rst: assert property (p_rst) else $error("reset not driven");
	property p_hold; $rose(o_reset_pin_oe_b) |-> low_cnt >= 12'(HMIN); endproperty
	a_hold: assert property (p_hold) else $error("reset hold short");
	property p_pwr; (o_ovuv_power & ~o_off_power) == 7'h00; endproperty
	a_pwr: assert property (p_pwr) else $error("ovuv on, off not");
	property p_rld; o_reload_defaults |=> !o_reload_defaults; endproperty
	a_rld: assert property (p_rld) else $error("reload not a pulse");
	c_err: cover property (o_pslverr);
	c_rel: cover property ($rose(o_reset_pin_oe_b));
	c_rld: cover property (o_reload_defaults);
endmodule
bind swsr_top swsr_checker #(.P_HOLD_CYC(P_HOLD_CYC)) u_swsr_checker (.*);

// ===== test/swsr_ctrl_model.sv
// Controller model: answers the watchdog challenge key
module swsr_ctrl_model (
	input  wire logic [7:0] i_key, // Key read back
	output logic      [7:0] o_ans  // Response to write
);
	timeunit 1ns;
	timeprecision 100ps;
	assign o_ans = {i_key[6:0], ^{i_key[7], i_key[5:3]}};
endmodule

// ===== test/swsr_top_test.sv
// Self-checking bench for the supervisor core
module swsr_top_test;
	import swsr_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_mclk, i_rst_b, i_ce, i_psel, i_penable, i_pwrite, err;
	logic i_primary_enable_input, i_secondary_enable_input, i_reset_pin_in;
	logic o_pready, o_pslverr, o_reset_pin_out, o_reset_pin_oe_b;
	logic o_reload_defaults;
	logic [7:0] i_paddr, key, ans;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic [6:0] i_rail_uv_ok, i_rail_off, i_mon_fault;
	logic [6:0] o_ovuv_power, o_off_power;
	logic [7:0] ts[7];
	int fail_count, compares, t, n;
	int ex[7];
	// Wire level: pull-up unless the core pulls low
	assign i_reset_pin_in = o_reset_pin_oe_b ? 1'b1 : o_reset_pin_out;
	swsr_top #(.P_REC_BASE_CYC(10), .P_WD_BASE_CYC(10), .P_HOLD_CYC(20))
		u_swsr_top (.*);
	swsr_ctrl_model u_swsr_ctrl_model (.i_key(key), .o_ans(ans));
	initial
	begin
		i_mclk = 0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1;
		do @(posedge i_mclk); while (o_pready !== 1'b1 && ++n < 20);
		rd = o_prdata;
		err = o_pslverr;
		if (o_pready !== 1'b1)
			fail_count++;
		i_psel <= 0;
		i_penable <= 0;
		@(posedge i_mclk);
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		compares++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(s, e, rd);
	endtask
	task automatic rel;
		n = 0;
		while (o_reset_pin_oe_b !== 1'b1 && n++ < 3000)
			@(posedge i_mclk);
		if (o_reset_pin_oe_b !== 1'b1)
			fail_count++;
	endtask
	task automatic summarize;
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		{i_rst_b, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = 0;
		{i_primary_enable_input, i_secondary_enable_input, key} = 0;
		{i_rail_uv_ok, i_rail_off, i_mon_fault} = 0;
		i_ce = 1;
		void'($urandom(49249));
		repeat (20) @(posedge i_mclk);
		i_rst_b <= 1;
		chk("oe_b", 0, o_reset_pin_oe_b);
		rdc("win", ADDR_WD_WIN, 32'h11);
		rdc("rctl", ADDR_RST_CTL, 32'h80);
		rdc("key", ADDR_WD_KEY, 32'h5a);
		apb(0, 8'h5c, 0);
		chk("err", 1, err);
		apb(1, ADDR_MON_CFG, 32'h7f);
		repeat (8) @(posedge i_mclk);
		chk("pwr", 32'h3fff, {o_ovuv_power, o_off_power});
		i_primary_enable_input <= 1;
		t = 0;
		for (int i = 0; i < 7; i++)
		begin
			n = 15 + $urandom % 30;
			t += n;
			ex[i] = t;
			i_mon_fault <= 7'($urandom);
			repeat (n) @(posedge i_mclk);
			i_rail_uv_ok[i] <= 1;
		end
		repeat (10) @(posedge i_mclk);
		rdc("stat", ADDR_REC_STAT, 32'h01);
		for (int i = 0; i < 7; i++)
		begin
			apb(0, 8'h40 + 8'(4 * i), 0);
			ts[i] = rd[7:0];
			chk("ts", 1, 8'(ts[i] - 8'(ex[i] / 10) + 8'd1) <= 8'd2);
		end
		// Falling primary edge records the power-down side
		i_primary_enable_input <= 0;
		repeat (30) @(posedge i_mclk);
		i_rail_off <= 7'h7f;
		i_rail_uv_ok <= 0;
		repeat (20) @(posedge i_mclk);
		rdc("stat", ADDR_REC_STAT, 32'h03);
		// Rails stay down, so this run lasts to the tick maximum
		i_primary_enable_input <= 1;
		repeat (20) @(posedge i_mclk);
		rdc("stat", ADDR_REC_STAT, 32'h17);
		rdc("ts0", 8'h40, 32'(ts[0]));
		repeat (2600) @(posedge i_mclk);
		rdc("stat", ADDR_REC_STAT, 32'h07);
		// Secondary start, reset asserted when the record completes
		apb(1, ADDR_REC_CFG, 32'h18);
		i_secondary_enable_input <= 1;
		repeat (20) @(posedge i_mclk);
		rdc("stat", ADDR_REC_STAT, 32'h37);
		i_rail_uv_ok <= 7'h7f;
		repeat (10) @(posedge i_mclk);
		chk("oe_b", 0, o_reset_pin_oe_b);
		rel;
		apb(1, ADDR_WD_CTL, 32'h08);
		repeat (8) @(posedge i_mclk);
		rdc("wst", ADDR_WD_STAT, 32'h08);
		apb(0, ADDR_WD_KEY, 0);
		key = rd[7:0];
		// Let the model's answer settle before it is sent
		@(posedge i_mclk);
		apb(1, ADDR_WD_KEY, 32'(ans));
		rdc("wst", ADDR_WD_STAT, 32'h00);
		rdc("key", ADDR_WD_KEY, 32'(ans));
		apb(1, ADDR_WD_KEY, 32'(ans));
		repeat (3) @(posedge i_mclk);
		chk("oe_b", 0, o_reset_pin_oe_b);
		rdc("wst", ADDR_WD_STAT, 32'h04);
		rdc("wst", ADDR_WD_STAT, 32'h00);
		rel;
		repeat (6) @(posedge i_mclk);
		rdc("wst", ADDR_WD_STAT, 32'h08);
		repeat (130) @(posedge i_mclk);
		chk("oe_b", 1, o_reset_pin_oe_b);
		repeat (40) @(posedge i_mclk);
		chk("oe_b", 0, o_reset_pin_oe_b);
		rdc("wst", ADDR_WD_STAT, 32'h01);
		rel;
		// Two-violation policy: stale key is wrong, then an early refresh
		apb(1, ADDR_WD_CTL, 32'h18);
		repeat (6) @(posedge i_mclk);
		apb(1, ADDR_WD_KEY, 32'(ans));
		chk("oe_b", 1, o_reset_pin_oe_b);
		rdc("wst", ADDR_WD_STAT, 32'h02);
		apb(1, ADDR_WD_KEY, 32'(ans));
		repeat (3) @(posedge i_mclk);
		chk("oe_b", 0, o_reset_pin_oe_b);
		rdc("wst", ADDR_WD_STAT, 32'h04);
		rel;
		apb(1, ADDR_WD_DIV, 32'h40);
		repeat (6) @(posedge i_mclk);
		apb(1, ADDR_WD_KEY, 32'h00);
		rdc("wst", ADDR_WD_STAT, 32'h00);
		apb(1, ADDR_WD_LOCK, 1);
		apb(1, ADDR_WD_WIN, 32'h22);
		rdc("win", ADDR_WD_WIN, 32'h11);
		summarize;
	end
	initial
	begin
		#200000;
		fail_count++;
		summarize;
	end
endmodule
